// ---- src/madc_top.sv ----
// converter control, channel latch, result buffer and bus slave
`timescale 1ns/10ps
`default_nettype none
// Contract
// - a high pulse on conv_start begins converting the latched channel.
// - conv_done goes low after a start and stays low through the conversion.
// - conv_done returns high when the conversion ends, once per start accepted in idle; a start while busy gives no rise.
// - the result appears as conv_done rises and holds until its next rise.
// - result_bus is undriven while result_drive_en is 0 and driven while 1.
// - the channel address is captured on the rising edge of chan_latch.
// - the latched address selects exactly one of the eight analog inputs.
// - each conversion yields an 8-bit binary result on the parallel bus.
// - all sequencing runs from the single clock.
// - the sample-and-hold tracks for at least 390 ns (98 clocks of 4 ns, 392 ns) before the input is held.
// - the held result is separate from the working code of a conversion.
module madc_top
    import madc_pkg::*;
#(
    parameter int unsigned ACQ_COUNT = ACQ_CYC,
    parameter int unsigned BIT_COUNT = BIT_CYC
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             irq,
    input  wire logic        conv_start,
    output logic             conv_done,
    input  wire logic        chan_latch,
    input  wire logic        channel_select_bit2,
    input  wire logic        channel_select_bit1,
    input  wire logic        channel_select_bit0,
    input  wire logic        result_drive_en,
    output logic [7:0]       result_bus_out,
    output logic [7:0]       result_bus_oe,
    input  wire logic        comp_hi,
    output logic [7:0]       dac_code,
    output logic             sh_track,
    output logic [7:0]       analog_input_select
);
    localparam int unsigned AW = $clog2(ACQ_COUNT + 1);
    localparam logic [AW-1:0] ACQ_LAST = AW'(ACQ_COUNT - 1);

    function automatic logic [7:0] chan_decode(input logic [2:0] a);
        chan_decode = 8'h01 << a;
    endfunction

    madc_state_t   state_r;
    logic [AW-1:0] acq_cnt_r;
    logic          start_q_r;
    logic          latch_q_r;
    logic [2:0]    chan_r;
    logic [7:0]    result_r;
    logic          done_r;
    logic          pin_en_r;
    logic          soft_start_r;
    logic [1:0]    irq_stat_r;
    logic [1:0]    irq_mask_r;
    logic [31:0]   hrdata_r;
    logic          wr_pend_r;
    logic [7:0]    wr_addr_r;
    logic          start_req;
    logic          begin_conv;
    logic          bit_tick;
    logic          sar_finish;
    logic [7:0]    sar_code;
    logic          addr_ph;
    logic [7:0]    rd_addr;
    logic [1:0]    irq_set;
    logic [1:0]    irq_clr;

    // ---------------------------------------------------------------
    // start detection and sequencing
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_q_r <= 1'b0;
            latch_q_r <= 1'b0;
        end
        else
        begin
            start_q_r <= conv_start;
            latch_q_r <= chan_latch;
        end
    end

    assign start_req  = (pin_en_r && conv_start && !start_q_r) || soft_start_r;
    assign begin_conv = start_req && (state_r == MADC_IDLE);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_r <= MADC_IDLE;
        else
        begin
            case (state_r)
                MADC_IDLE:
                    if (begin_conv)
                        state_r <= MADC_ACQ;
                MADC_ACQ:
                    if (acq_cnt_r == ACQ_LAST)
                        state_r <= MADC_CONV;
                MADC_CONV:
                    if (sar_finish)
                        state_r <= MADC_IDLE;
                default:
                    state_r <= MADC_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            acq_cnt_r <= '0;
        else if (state_r == MADC_ACQ)
            acq_cnt_r <= acq_cnt_r + AW'(1);
        else
            acq_cnt_r <= '0;
    end

    assign sh_track = (state_r == MADC_ACQ);

    // ---------------------------------------------------------------
    // bit timing and approximation
    // ---------------------------------------------------------------
    madc_tick_div #(.DIV(BIT_COUNT)) u_div
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (state_r == MADC_CONV),
        .tick    (bit_tick)
    );

    madc_sar #(.N(RES_BITS)) u_sar
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (state_r == MADC_ACQ && acq_cnt_r == ACQ_LAST),
        .step    (bit_tick),
        .comp_hi (comp_hi),
        .code    (sar_code),
        .finish  (sar_finish)
    );

    assign dac_code = sar_code;

    // ---------------------------------------------------------------
    // done flag and held result
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            done_r <= 1'b1;
        else if (begin_conv)
            done_r <= 1'b0;
        else if (state_r == MADC_CONV && sar_finish)
            done_r <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            result_r <= RESULT_RST;
        else if (state_r == MADC_CONV && sar_finish)
            result_r <= {sar_code[7:1], comp_hi};
    end

    assign conv_done      = done_r;
    assign result_bus_out = result_r;
    assign result_bus_oe  = {8{result_drive_en}};

    // ---------------------------------------------------------------
    // channel address latch
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            chan_r <= CHAN_RST;
        else if (chan_latch && !latch_q_r)
            chan_r <= {channel_select_bit2, channel_select_bit1, channel_select_bit0};
    end

    assign analog_input_select = chan_decode(chan_r);

    // ---------------------------------------------------------------
    // bus slave, zero wait state
    // ---------------------------------------------------------------
    assign addr_ph   = hsel && htrans[1] && hready;
    assign rd_addr   = haddr[7:0];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= addr_ph && hwrite;
            if (addr_ph)
                wr_addr_r <= rd_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= 32'h0000_0000;
        else if (addr_ph && !hwrite)
        begin
            case (rd_addr)
                ADDR_CTRL:     hrdata_r <= 32'(pin_en_r) << CTRL_PIN_EN;
                ADDR_STATUS:   hrdata_r <= (32'(done_r) << STAT_DONE)
                                           | (32'(state_r != MADC_IDLE) << STAT_BUSY)
                                           | (32'(chan_r) << STAT_CHAN_LSB);
                ADDR_RESULT:   hrdata_r <= 32'(result_r);
                ADDR_IRQ_STAT: hrdata_r <= 32'(irq_stat_r);
                ADDR_IRQ_MASK: hrdata_r <= 32'(irq_mask_r);
                default:       hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_en_r     <= CTRL_PIN_EN_RST;
            soft_start_r <= 1'b0;
            irq_mask_r   <= IRQ_MASK_RST;
        end
        else
        begin
            soft_start_r <= wr_pend_r && wr_addr_r == ADDR_CTRL && hwdata[CTRL_SOFT_START];
            if (wr_pend_r && wr_addr_r == ADDR_CTRL)
                pin_en_r <= hwdata[CTRL_PIN_EN];
            if (wr_pend_r && wr_addr_r == ADDR_IRQ_MASK)
                irq_mask_r <= hwdata[IRQ_BITS-1:0];
        end
    end

    // ---------------------------------------------------------------
    // sticky events, write one to clear, set wins
    // ---------------------------------------------------------------
    assign irq_set[IRQ_DONE]    = state_r == MADC_CONV && sar_finish;
    assign irq_set[IRQ_OVERRUN] = start_req && state_r != MADC_IDLE;
    assign irq_clr = (wr_pend_r && wr_addr_r == ADDR_IRQ_STAT) ? hwdata[IRQ_BITS-1:0] : 2'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_stat_r <= 2'h0;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [AW:0] trk_len_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            trk_len_r <= '0;
        else if (sh_track)
            trk_len_r <= trk_len_r + (AW+1)'(1);
        else
            trk_len_r <= '0;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_start_begins;
        (pin_en_r && conv_start && !start_q_r && state_r == MADC_IDLE) |=> sh_track;
    endproperty
    a_start_begins: assert property (p_start_begins) else $error("start ignored");

    property p_done_low_busy;
        (state_r != MADC_IDLE) |-> !conv_done;
    endproperty
    a_done_low_busy: assert property (p_done_low_busy) else $error("done high in conversion");

    property p_done_rise;
        (state_r == MADC_CONV && sar_finish) |=> conv_done && state_r == MADC_IDLE;
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done did not rise");

    property p_result_hold;
        !$stable(result_bus_out) |-> $rose(conv_done);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved off done edge");

    property p_bus_drive;
        result_drive_en ? (result_bus_oe == 8'hff && result_bus_out == result_r)
                        : (result_bus_oe == 8'h00);
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus drive wrong");

    property p_chan_latch;
        (chan_latch && !latch_q_r) |=> chan_r == $past({channel_select_bit2,
                                        channel_select_bit1, channel_select_bit0});
    endproperty
    a_chan_latch: assert property (p_chan_latch) else $error("channel not latched");

    property p_one_chan;
        $onehot(analog_input_select) && analog_input_select[chan_r];
    endproperty
    a_one_chan: assert property (p_one_chan) else $error("mux select not one-hot");

    property p_result_code;
        (state_r == MADC_CONV && sar_finish) |=> result_r == {$past(sar_code[7:1]), $past(comp_hi)};
    endproperty
    a_result_code: assert property (p_result_code) else $error("result not final code");

    property p_tick_only_conv;
        bit_tick |-> state_r == MADC_CONV;
    endproperty
    a_tick_only_conv: assert property (p_tick_only_conv) else $error("step outside conversion");

    property p_acq_len;
        $fell(sh_track) |-> $past(trk_len_r) == (AW+1)'(ACQ_COUNT - 1);
    endproperty
    a_acq_len: assert property (p_acq_len) else $error("tracking length wrong");

    property p_buffered;
        (state_r != MADC_IDLE && !sar_finish) |=> $stable(result_r);
    endproperty
    a_buffered: assert property (p_buffered) else $error("held result disturbed");

    c_conv_done:   cover property ($rose(conv_done));
    c_overrun:     cover property (irq_set[IRQ_OVERRUN]);
    c_irq:         cover property ($rose(irq));
    c_latch_track: cover property (chan_latch && !latch_q_r && sh_track);
endmodule
`default_nettype wire

// ---- src/madc_pkg.sv ----
// shared constants of the multiplexed converter control block
package madc_pkg;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned ACQ_TIME_PS   = 390000;
    localparam int unsigned CONV_TIME_PS  = 6600000;
    localparam int unsigned RES_BITS      = 8;
    localparam int unsigned CHAN_COUNT    = 8;
    // least time rounds up, longest rounds down
    localparam int unsigned ACQ_CYC  = (ACQ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CONV_CYC = CONV_TIME_PS / CLK_PERIOD_PS;
    localparam int unsigned BIT_CYC  = (CONV_CYC - ACQ_CYC) / RES_BITS;

    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_RESULT   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    localparam int unsigned CTRL_SOFT_START = 0;
    localparam int unsigned CTRL_PIN_EN     = 1;
    localparam int unsigned STAT_DONE       = 0;
    localparam int unsigned STAT_BUSY       = 1;
    localparam int unsigned STAT_CHAN_LSB   = 4;
    localparam int unsigned IRQ_DONE        = 0;
    localparam int unsigned IRQ_OVERRUN     = 1;
    localparam int unsigned IRQ_BITS        = 2;

    localparam logic        CTRL_PIN_EN_RST = 1'b1;
    localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;
    localparam logic [7:0]  RESULT_RST      = 8'h00;
    localparam logic [2:0]  CHAN_RST        = 3'h0;

    typedef enum logic [2:0]
    {
        MADC_IDLE = 3'b001,
        MADC_ACQ  = 3'b010,
        MADC_CONV = 3'b100
    } madc_state_t;
endpackage

// ---- src/madc_tick_div.sv ----
// divider giving one-cycle step enables while running
`timescale 1ns/10ps
`default_nettype none
module madc_tick_div
    import madc_pkg::*;
#(
    parameter int unsigned DIV = BIT_CYC
)
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic run,
    output logic      tick
);
    localparam int unsigned W = $clog2(DIV + 1);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_r;

    // ---------------------------------------------------------------
    // counter restarts whenever run is low
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_r <= '0;
        else if (!run || cnt_r == LAST)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + W'(1);
    end

    assign tick = run && (cnt_r == LAST);
endmodule
`default_nettype wire

// ---- src/madc_sar.sv ----
// successive approximation register with separate working code
`timescale 1ns/10ps
`default_nettype none
module madc_sar
    import madc_pkg::*;
#(
    parameter int unsigned N = RES_BITS
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         load,
    input  wire logic         step,
    input  wire logic         comp_hi,
    output logic [N-1:0]      code,
    output logic              finish
);
    localparam int unsigned IW = $clog2(N);

    logic [N-1:0]  code_r;
    logic [IW-1:0] idx_r;
    logic          busy_r;

    assign code   = code_r;
    assign finish = busy_r && step && (idx_r == '0);

    // ---------------------------------------------------------------
    // trial bit kept when input is at or above the trial level
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            code_r <= '0;
            idx_r  <= '0;
            busy_r <= 1'b0;
        end
        else if (load)
        begin
            code_r <= N'(1) << (N - 1);
            idx_r  <= IW'(N - 1);
            busy_r <= 1'b1;
        end
        else if (busy_r && step)
        begin
            code_r[idx_r] <= comp_hi;
            if (idx_r == '0)
                busy_r <= 1'b0;
            else
            begin
                code_r[idx_r - IW'(1)] <= 1'b1;
                idx_r <= idx_r - IW'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/madc_analog_model.sv ----
// analog front end model: channel mux, sample-and-hold and comparator
`timescale 1ns/10ps
`default_nettype none
module madc_analog_model
    import madc_pkg::*;
#(
    parameter logic [63:0] LEVELS = 64'h0
)
(
    input  wire logic       hclk,
    input  wire logic       sh_track,
    input  wire logic [7:0] analog_input_select,
    input  wire logic [7:0] dac_code,
    output logic            comp_hi
);
    logic [7:0] held_r;
    logic [7:0] pick;

    // -----------------------------------------
    // mux: a select that is not one-hot gives a moving level
    // -----------------------------------------
    always_comb
    begin
        pick = ~held_r;
        for (int i = 0; i < 8; i++)
            if (analog_input_select == (8'h01 << i))
                pick = LEVELS[i*8 +: 8];
    end

    // -----------------------------------------
    // hold: level frozen once tracking stops
    // -----------------------------------------
    always_ff @(posedge hclk)
        if (sh_track)
            held_r <= pick;

    assign comp_hi = (held_r >= dac_code);
endmodule
`default_nettype wire

// ---- bench/mux_adc_parallel_interface_tb_top.sv ----
// self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module mux_adc_parallel_interface_tb_top
    import madc_pkg::*;
;
    localparam int unsigned ACQ_N  = 4;
    localparam int unsigned BIT_N  = 3;
    localparam int unsigned CONV_N = ACQ_N + 8*BIT_N;
    localparam logic [63:0] LEVELS = 64'haa55_fe01_7f80_ff00;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        irq;
    logic        conv_start;
    logic        conv_done;
    logic        chan_latch;
    logic [2:0]  chan_sel;
    logic        result_drive_en;
    logic [7:0]  result_bus_out;
    logic [7:0]  result_bus_oe;
    logic        comp_hi;
    logic [7:0]  dac_code;
    logic        sh_track;
    logic [7:0]  analog_input_select;
    logic [31:0] d;
    int          n_fail;
    int          check_count;

    assign hready = hreadyout;

    madc_top #(.ACQ_COUNT(ACQ_N), .BIT_COUNT(BIT_N)) dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
        .conv_start(conv_start), .conv_done(conv_done), .chan_latch(chan_latch),
        .channel_select_bit2(chan_sel[2]), .channel_select_bit1(chan_sel[1]),
        .channel_select_bit0(chan_sel[0]), .result_drive_en(result_drive_en),
        .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe),
        .comp_hi(comp_hi), .dac_code(dac_code), .sh_track(sh_track),
        .analog_input_select(analog_input_select)
    );

    madc_analog_model #(.LEVELS(LEVELS)) afe
    (
        .hclk(hclk), .sh_track(sh_track), .analog_input_select(analog_input_select),
        .dac_code(dac_code), .comp_hi(comp_hi)
    );

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // -----------------------------------------
    // checking and closing
    // -----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic give_up();
        n_fail++;
        tally_and_finish();
    endtask

    // -----------------------------------------
    // bus master
    // -----------------------------------------
    task automatic wait_hready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (n >= 50)
            give_up();
    endtask

    task automatic bus_req(input logic [31:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_hready();
        hsel <= 1'b0;
        htrans <= 2'b00;
    endtask

    task automatic ahb_rd(input logic [31:0] a, output logic [31:0] v);
        bus_req(a, 1'b0);
        wait_hready();
        v = hrdata;
    endtask

    task automatic ahb_wr(input logic [31:0] a, input logic [31:0] v);
        bus_req(a, 1'b1);
        hwdata <= v;
        wait_hready();
    endtask

    // -----------------------------------------
    // host pins
    // -----------------------------------------
    task automatic start_pin();
        @(posedge hclk);
        conv_start <= 1'b1;
        @(posedge hclk);
        conv_start <= 1'b0;
    endtask

    task automatic latch_chan(input logic [2:0] ch);
        @(posedge hclk);
        chan_sel <= ch;
        chan_latch <= 1'b1;
        @(posedge hclk);
        chan_latch <= 1'b0;
        chan_sel <= ~ch;
        repeat (2) @(posedge hclk);
        #1;
        chk("input select", 32'(8'h01 << ch), 32'(analog_input_select));
    endtask

    task automatic run_conv(input logic [2:0] ch, input bit pin, input bit twice);
        logic [7:0] prev;
        int n;
        int trk;
        prev = result_bus_out;
        n = 0;
        trk = 0;
        if (pin)
        begin
            start_pin();
            #1;
            trk = int'(sh_track === 1'b1);
        end
        else
            ahb_wr(32'(ADDR_CTRL), 32'h3);
        do
        begin
            @(posedge hclk);
            n++;
            if (twice && n == 8)
                conv_start <= 1'b1;
            if (twice && n == 9)
                conv_start <= 1'b0;
            #1;
            trk += int'(sh_track === 1'b1);
            if (n == 1)
                chk("done low", 32'h0, 32'(conv_done));
            if (n == 12)
                chk("held result", 32'(prev), 32'(result_bus_out));
        end
        while (conv_done !== 1'b1 && n < 200);
        if (n >= 200)
            give_up();
        chk("conversion length", pin ? CONV_N : CONV_N + 1, n);
        chk("track cycles", ACQ_N, trk);
        chk("result", 32'(LEVELS[ch*8 +: 8]), 32'(result_bus_out));
        chk("dac code", 32'(LEVELS[ch*8 +: 8]), 32'(dac_code));
        ahb_rd(32'(ADDR_RESULT), d);
        chk("result reg", 32'(LEVELS[ch*8 +: 8]), d);
        ahb_rd(32'(ADDR_STATUS), d);
        chk("status", 32'({ch, 1'b0}), 32'({d[6:4], d[1]}));
    endtask

    task automatic irq_step(input logic [7:0] a, input logic [31:0] v,
                            input logic i_exp, input logic [31:0] s_exp);
        ahb_wr(32'(a), v);
        @(posedge hclk);
        #1;
        chk("irq", 32'(i_exp), 32'(irq));
        ahb_rd(32'(ADDR_IRQ_STAT), d);
        chk("irq status", s_exp, d);
    endtask

    // -----------------------------------------
    // main sequence
    // -----------------------------------------
    initial
    begin
        n_fail = 0;
        check_count = 0;
        hresetn = 1'b0;
        {hsel, hwrite, conv_start, chan_latch, result_drive_en} = 5'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        chan_sel = 3'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("reset done", 32'h1, 32'(conv_done));
        chk("reset result", 32'(RESULT_RST), 32'(result_bus_out));
        chk("reset select", 32'(8'h01 << CHAN_RST), 32'(analog_input_select));
        chk("reset irq", 32'h0, 32'({irq, hresp}));
        ahb_rd(32'(ADDR_CTRL), d);
        chk("ctrl reset", 32'(CTRL_PIN_EN_RST) << CTRL_PIN_EN, d);
        ahb_rd(32'(ADDR_IRQ_MASK), d);
        chk("mask reset", 32'(IRQ_MASK_RST), d);
        ahb_wr(32'h40, 32'hffff_ffff);
        ahb_rd(32'h40, d);
        chk("unmapped", 32'h0, d);
        for (int e = 0; e < 2; e++)
        begin
            @(posedge hclk);
            result_drive_en <= e[0];
            @(posedge hclk);
            #1;
            chk("bus enable", 32'({8{e[0]}}), 32'(result_bus_oe));
        end
        for (int c = 0; c < 8; c++)
        begin
            latch_chan(c[2:0]);
            run_conv(c[2:0], 1'b1, c == 3);
        end
        ahb_rd(32'(ADDR_IRQ_STAT), d);
        chk("irq status", 32'h3, d);
        chk("irq masked", 32'h0, 32'(irq));
        irq_step(ADDR_IRQ_MASK, 32'h1, 1'b1, 32'h3);
        irq_step(ADDR_IRQ_STAT, 32'h1, 1'b0, 32'h2);
        irq_step(ADDR_IRQ_MASK, 32'h2, 1'b1, 32'h2);
        irq_step(ADDR_IRQ_STAT, 32'h2, 1'b0, 32'h0);
        ahb_wr(32'(ADDR_CTRL), 32'h0);
        start_pin();
        repeat (5) @(posedge hclk);
        #1;
        chk("pin disabled", 32'h1, 32'(conv_done));
        latch_chan(3'h6);
        run_conv(3'h6, 1'b0, 1'b0);
        start_pin();
        repeat (10) @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        chk("mid reset", 32'h200, 32'({conv_done, sh_track, result_bus_out}));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        latch_chan(3'h2);
        run_conv(3'h2, 1'b1, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
